// *** hdl/ccr_pkg.sv ***
package ccr_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_MAIN_CONFIGURATION = 4'h0;
    localparam logic [3:0]  ADDR_RESERVED_WORD_ONE  = 4'h1;
    localparam logic [15:0] MAIN_CONFIGURATION_RST  = 16'h2000;
    localparam logic [15:0] RESERVED_WORD_ONE_RST   = 16'h2a0e;

    // ------------------------------------------------------------
    // main configuration word fields
    // ------------------------------------------------------------
    localparam int BIT_CAL_TRIGGER     = 15;
    localparam int BIT_CLOCK_PHASE_SEL = 14;
    localparam int BIT_SWING_SEL       = 13;
    localparam int BIT_FIXED_PATTERN   = 12;
    localparam int BIT_FIRST_SLEEP     = 11;
    localparam int BIT_SECOND_SLEEP    = 10;
    localparam int BIT_SLOW_CLOCK_OPT  = 8;
    localparam int BIT_INTERLEAVE_EN   = 7;
    localparam int BIT_INPUT_PICK      = 6;
    localparam int BIT_INPUT_TIE       = 5;
    localparam int BIT_SIGNED_FORMAT   = 4;
    localparam int BIT_STAMP_ENABLE    = 3;

    // ------------------------------------------------------------
    // serial access cycle
    // ------------------------------------------------------------
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] CMD_BITS   = 5'h08;
    localparam int         FRM_RW_BIT = 23;
    localparam int         FRM_ADDR_H = 20;
    localparam int         FRM_ADDR_L = 17;

    // ------------------------------------------------------------
    // synchronised pin vector positions
    // ------------------------------------------------------------
    localparam int P_SCLK  = 7;
    localparam int P_SCS_B = 6;
    localparam int P_SDI   = 5;
    localparam int P_SEL   = 4;
    localparam int P_CAL   = 3;
    localparam int P_SLP1  = 2;
    localparam int P_SLP2  = 1;
    localparam int P_DEMUX = 0;
    localparam logic [7:0] SYNC_RST = 8'h50;

    typedef struct packed {
        logic [7:0]  sync_m;
        logic [7:0]  sync_s;
        logic        sclk_d;
        logic [4:0]  cnt;
        logic [23:0] shin;
        logic        rd;
        logic [15:0] shout;
        logic        sdo;
        logic        sdo_oe;
        logic [15:0] cfg;
        logic [15:0] rsv;
        logic        cal_prev;
        logic        cal_start;
        logic [15:0] eff;
    } ccr_state_s;

endpackage

// *** hdl/ccr_main_config.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: writing one to the top bit starts calibration; bit never self-clears
// R2: host clears the trigger bit then sets it again for another run
// R3: trigger bit ORed with calibration pin; launch only after both low
// R4: in double-rate output, phase bit picks 0 or 90 degree relation
// R5: without demultiplexing, phase bit ignored, 0 degree relation used
// R6: swing bit chooses lower or higher differential output level
// R7: pattern bit one drives fixed pattern, zero drives converted samples
// R8: first channel sleeps when its bit or its pin is set
// R9: second channel sleeps when its bit or its pin is set
// R10: host always writes zero to bit nine of the main word
// R11: host should set slow-clock bit for low sampling clock rates
// R12: interleave bit selects two-channel or dual-edge interleaved sampling
// R13: in interleave, pick bit selects first or second analog input
// R14: in interleave, tie bit joins both analog inputs internally
// R15: host programs interleave bits to 101 for tied-input operation
// R16: format bit selects offset binary or two's complement samples
// R17: stamp bit turns time stamp output on, default off
// R18: power-on value of main word has only the swing bit set
// R19: host writes the reserved word only with its default value
// R20: each access is one 24-bit cycle, command then 16 data bits
// R21: configuration words have no effect outside extended control mode
// R22: leaving extended control mode returns words to power-on values
// R23: write replaces all sixteen bits at cycle end; read returns stored
module ccr_main_config
    import ccr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic        i_sclk,
    input  wire logic        i_scs_b,
    input  wire logic        i_sdi,
    output logic             o_sdo,
    output logic             o_sdo_oe,
    input  wire logic        i_serial_control_select_pin,
    input  wire logic        i_cal_pin,
    input  wire logic        i_first_channel_sleep_pin,
    input  wire logic        i_second_channel_sleep_pin,
    input  wire logic        i_demux_mode,
    output logic             o_cal_start,
    output logic             o_output_clock_phase_sel,
    output logic             o_swing_high,
    output logic             o_fixed_pattern_sel,
    output logic             o_first_channel_sleep,
    output logic             o_second_channel_sleep,
    output logic             o_slow_sample_clock_opt,
    output logic             o_interleave_en,
    output logic             o_interleave_input_pick,
    output logic             o_interleave_input_tie,
    output logic             o_signed_output_format,
    output logic             o_stamp_enable,
    output logic             o_extended_serial_control_mode,
    output logic [15:0]      o_main_configuration,
    output logic [15:0]      o_reserved_word_one
);

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    ccr_state_s  q;
    ccr_state_s  next_q;
    logic        extended_serial_control_mode;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        wr_fire;
    logic        cal_or;
    logic [23:0] frame;
    logic [7:0]  cmd;
    logic [3:0]  wr_addr;
    logic [15:0] e;

    // mode select pin low means extended control mode
    assign extended_serial_control_mode       = ~q.sync_s[P_SEL];
    assign sclk_rise = q.sync_s[P_SCLK] & ~q.sclk_d;
    assign sclk_fall = ~q.sync_s[P_SCLK] & q.sclk_d;
    assign frame     = {q.shin[22:0], q.sync_s[P_SDI]};
    assign cmd       = frame[7:0];
    assign wr_addr   = frame[FRM_ADDR_H:FRM_ADDR_L];
    // R20: write lands on 24th rising edge
    assign wr_fire   = ~q.sync_s[P_SCS_B] & sclk_rise
                       & (q.cnt == FRAME_BITS - 5'h01) & ~frame[FRM_RW_BIT];
    // R1 R3: trigger bit or pin
    assign cal_or    = (extended_serial_control_mode & q.cfg[BIT_CAL_TRIGGER]) | q.sync_s[P_CAL];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_q        = q;
        e             = MAIN_CONFIGURATION_RST;
        // pins reach logic only through two flops
        next_q.sync_m = {i_sclk, i_scs_b, i_sdi, i_serial_control_select_pin,
                         i_cal_pin, i_first_channel_sleep_pin,
                         i_second_channel_sleep_pin, i_demux_mode};
        next_q.sync_s = q.sync_m;
        next_q.sclk_d = q.sync_s[P_SCLK];

        if (q.sync_s[P_SCS_B]) begin
            // R20: raising select aborts a short cycle without a write
            next_q.cnt    = 5'h00;
            next_q.rd     = 1'b0;
            next_q.sdo    = 1'b0;
            next_q.sdo_oe = 1'b0;
        end else if (sclk_rise && q.cnt != FRAME_BITS) begin
            next_q.cnt  = q.cnt + 5'h01;
            next_q.shin = frame;
            if (q.cnt == CMD_BITS - 5'h01) begin
                next_q.rd = cmd[7];
                // R23: read returns stored word; unmapped reads zero
                // address sits one bit above the don't-care bit
                case (cmd[FRM_ADDR_H-16:FRM_ADDR_L-16])
                    ADDR_MAIN_CONFIGURATION: next_q.shout = q.cfg;
                    ADDR_RESERVED_WORD_ONE:  next_q.shout = q.rsv;
                    default:                 next_q.shout = 16'h0000;
                endcase
            end
        end else if (sclk_fall && q.rd && q.cnt >= CMD_BITS
                     && q.cnt < FRAME_BITS) begin
            // msb first from the 8th falling edge; d0 then holds
            next_q.sdo    = q.shout[15];
            next_q.shout  = {q.shout[14:0], 1'b0};
            next_q.sdo_oe = 1'b1;
        end

        // R23: whole word replaced at once
        if (wr_fire && wr_addr == ADDR_MAIN_CONFIGURATION) begin
            next_q.cfg = frame[15:0];
        end
        if (wr_fire && wr_addr == ADDR_RESERVED_WORD_ONE) begin
            next_q.rsv = frame[15:0];
        end
        // R22: outside extended mode the words sit at defaults
        if (!extended_serial_control_mode) begin
            next_q.cfg = MAIN_CONFIGURATION_RST;
            next_q.rsv = RESERVED_WORD_ONE_RST;
        end

        // R3: launch only on a rise of the combined level
        next_q.cal_prev  = cal_or;
        next_q.cal_start = cal_or & ~q.cal_prev;

        // R21: words steer nothing outside extended mode
        if (extended_serial_control_mode) begin
            e = q.cfg;
        end
        // R5: phase select ignored without demultiplexing
        if (!q.sync_s[P_DEMUX]) begin
            e[BIT_CLOCK_PHASE_SEL] = 1'b0;
        end
        // R8: first channel sleep pin stays active
        e[BIT_FIRST_SLEEP]  = e[BIT_FIRST_SLEEP] | q.sync_s[P_SLP1];
        // R9: second channel sleep pin stays active
        e[BIT_SECOND_SLEEP] = e[BIT_SECOND_SLEEP] | q.sync_s[P_SLP2];
        next_q.eff = e;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q        <= '0;
            q.sync_m <= SYNC_RST;
            q.sync_s <= SYNC_RST;
            // R18: power-on values
            q.cfg    <= MAIN_CONFIGURATION_RST;
            q.rsv    <= RESERVED_WORD_ONE_RST;
            q.eff    <= MAIN_CONFIGURATION_RST;
        end else if (i_ce) begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the trigger bit is left set after a run, only a 0-then-1 relaunches
    assign o_cal_start                    = q.cal_start;
    // R4: phase relation in double-rate output
    assign o_output_clock_phase_sel       = q.eff[BIT_CLOCK_PHASE_SEL];
    // R6: output swing
    assign o_swing_high                   = q.eff[BIT_SWING_SEL];
    // R7: fixed pattern or samples
    assign o_fixed_pattern_sel            = q.eff[BIT_FIXED_PATTERN];
    assign o_first_channel_sleep          = q.eff[BIT_FIRST_SLEEP];
    assign o_second_channel_sleep         = q.eff[BIT_SECOND_SLEEP];
    assign o_slow_sample_clock_opt        = q.eff[BIT_SLOW_CLOCK_OPT];
    // R12: interleaved sampling
    assign o_interleave_en                = q.eff[BIT_INTERLEAVE_EN];
    // R13: input pick only meaningful in interleave
    assign o_interleave_input_pick        = q.eff[BIT_INTERLEAVE_EN]
                                            & q.eff[BIT_INPUT_PICK];
    // R14: inputs tied only in interleave
    assign o_interleave_input_tie         = q.eff[BIT_INTERLEAVE_EN]
                                            & q.eff[BIT_INPUT_TIE];
    // R16: number format
    assign o_signed_output_format         = q.eff[BIT_SIGNED_FORMAT];
    // R17: time stamp
    assign o_stamp_enable                 = q.eff[BIT_STAMP_ENABLE];
    assign o_extended_serial_control_mode = extended_serial_control_mode;
    assign o_main_configuration           = q.cfg;
    assign o_reserved_word_one            = q.rsv;
    assign o_sdo                          = q.sdo;
    assign o_sdo_oe                       = q.sdo_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    a_cal_sticky: assert property ( // R1
        i_ce && extended_serial_control_mode && q.cfg[BIT_CAL_TRIGGER] && !wr_fire
        |=> q.cfg[BIT_CAL_TRIGGER] || !extended_serial_control_mode)
        else $error("calibration bit cleared itself");

    a_cal_launch: assert property ( // R3
        i_ce && cal_or && !q.cal_prev |=> o_cal_start ##1 !o_cal_start
        or (!i_ce))
        else $error("calibration launch not a single pulse");

    a_cal_needs_low: assert property ( // R3
        i_ce && q.cal_prev |=> !o_cal_start)
        else $error("calibration relaunched without low phase");

    a_phase_nodemux: assert property ( // R5
        i_ce && !q.sync_s[P_DEMUX] |=> !o_output_clock_phase_sel)
        else $error("phase select honoured without demultiplexing");

    a_phase_follow: assert property ( // R4
        i_ce && extended_serial_control_mode && q.sync_s[P_DEMUX]
        |=> o_output_clock_phase_sel == $past(q.cfg[BIT_CLOCK_PHASE_SEL]))
        else $error("phase select not followed");

    a_sleep_first: assert property ( // R8
        i_ce && q.sync_s[P_SLP1] |=> o_first_channel_sleep)
        else $error("first channel sleep pin ignored");

    a_sleep_second: assert property ( // R9
        i_ce && q.sync_s[P_SLP2] |=> o_second_channel_sleep)
        else $error("second channel sleep pin ignored");

    a_idle_default: assert property ( // R21
        i_ce && !extended_serial_control_mode |=> o_swing_high && !o_fixed_pattern_sel
        && !o_interleave_en && !o_signed_output_format && !o_stamp_enable)
        else $error("configuration acted outside extended mode");

    a_mode_exit: assert property ( // R22
        i_ce && !extended_serial_control_mode |=> q.cfg == MAIN_CONFIGURATION_RST
        && q.rsv == RESERVED_WORD_ONE_RST)
        else $error("words not returned to defaults");

    a_write_commit: assert property ( // R23
        i_ce && extended_serial_control_mode && wr_fire
        && wr_addr == ADDR_MAIN_CONFIGURATION
        |=> q.cfg == $past(frame[15:0]))
        else $error("main word write lost");

    a_frame_len: assert property ( // R20
        q.cnt <= FRAME_BITS)
        else $error("access cycle length broken");

    a_frame_abort: assert property ( // R20
        q.sync_s[P_SCS_B] && i_ce |=> q.cnt == 5'h00)
        else $error("access cycle not cleared on deselect");

    a_sdo_quiet: assert property ( // R20
        i_ce && q.cnt < CMD_BITS |=> !o_sdo_oe || $past(q.cnt) >= CMD_BITS)
        else $error("data driven during command field");

endmodule

// *** test/ccr_host_model.sv ***
`timescale 1ns/1ps
module ccr_host_model
    import ccr_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_sdo,
    output logic      o_sclk,
    output logic      o_scs_b,
    output logic      o_sdi
);
    // each serial clock phase lasts 6 system cycles, above the synchroniser
    localparam int HALF = 6;

    initial begin
        o_sclk  = 1'b0;
        o_scs_b = 1'b1;
        o_sdi   = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // one cycle of nbits bits (24 for a full access), command byte then data bits
    task automatic xfer(input logic rd, input logic [3:0] addr,
                        input logic [15:0] wdata, input int nbits,
                        output logic [15:0] rdata);
        logic [23:0] frame;
        logic [15:0] d;
        d = wdata;
        // bit nine of the main word goes out as zero
        if (addr == ADDR_MAIN_CONFIGURATION)
            d[9] = 1'b0;
        frame = {rd, 2'b10, addr, 1'b0, d};
        rdata = 16'h0000;
        @(posedge i_clk);
        o_scs_b <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            // once a read command is out, sdi carries a toggling pattern
            o_sdi <= (rd && i >= 8) ? i[0] : frame[23-i];
            wait_clk(HALF);
            o_sclk <= 1'b1;
            if (i >= 8)
                rdata[23-i] = i_sdo;
            wait_clk(HALF);
            o_sclk <= 1'b0;
        end
        wait_clk(HALF);
        o_scs_b <= 1'b1;
        // released sdi rests at its pull-up level
        o_sdi   <= 1'b1;
        wait_clk(2 * HALF);
    endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import ccr_pkg::*;
;
    typedef struct packed {
        logic [15:0] d;
        logic        dm;
        logic [10:0] ex;
    } ccr_row_s;

    logic        clk, rst_b, sclk, scs_b, sdi, sdo, sdo_oe, extended_serial_control_mode;
    logic        sel_pin, cal_pin, slp1_pin, slp2_pin, demux, cal_start;
    logic        ce;
    logic [10:0] ctrl;
    logic [15:0] main_w, rsv_w, rd_w;
    int          error_cnt, comparisons, base;
    int          cal_cnt = 0;
    // controls: phase swing pattern sleep1 sleep2 slow il pick tie fmt stamp
    // rows six and seven: slow-clock bit, tied-input pattern 101
    ccr_row_s    rows [10] = '{
        '{16'h4000, 1'b1, 11'h400}, '{16'h4000, 1'b0, 11'h000},
        '{16'h2000, 1'b1, 11'h200}, '{16'h1000, 1'b1, 11'h100},
        '{16'h0c00, 1'b0, 11'h0c0}, '{16'h0100, 1'b1, 11'h020},
        '{16'h00a0, 1'b1, 11'h014}, '{16'h00c0, 1'b1, 11'h018},
        '{16'h0060, 1'b1, 11'h000}, '{16'h0018, 1'b1, 11'h003}};

    ccr_main_config DUT (
        .i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_sclk(sclk),
        .i_scs_b(scs_b), .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
        .i_serial_control_select_pin(sel_pin), .i_cal_pin(cal_pin),
        .i_first_channel_sleep_pin(slp1_pin),
        .i_second_channel_sleep_pin(slp2_pin), .i_demux_mode(demux),
        .o_cal_start(cal_start), .o_output_clock_phase_sel(ctrl[10]),
        .o_swing_high(ctrl[9]), .o_fixed_pattern_sel(ctrl[8]),
        .o_first_channel_sleep(ctrl[7]), .o_second_channel_sleep(ctrl[6]),
        .o_slow_sample_clock_opt(ctrl[5]), .o_interleave_en(ctrl[4]),
        .o_interleave_input_pick(ctrl[3]), .o_interleave_input_tie(ctrl[2]),
        .o_signed_output_format(ctrl[1]), .o_stamp_enable(ctrl[0]),
        .o_extended_serial_control_mode(extended_serial_control_mode),
        .o_main_configuration(main_w), .o_reserved_word_one(rsv_w));

    ccr_host_model host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk),
                         .o_scs_b(scs_b), .o_sdi(sdi));

    always #2 clk = ~clk;

    always @(posedge clk)
        if (cal_start === 1'b1)
            cal_cnt <= cal_cnt + 1;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp,
                       input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input int n = 24);
        host.xfer(1'b0, a, d, n, rd_w);
        repeat (8) @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        host.xfer(1'b1, a, 16'h0000, 24, rd_w);
        chk("read data", e, rd_w);
    endtask

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        sel_pin = 1'b0;
        cal_pin = 1'b0;
        slp1_pin = 1'b0;
        slp2_pin = 1'b0;
        demux = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        chk("main reset", MAIN_CONFIGURATION_RST, main_w);
        chk("rsv reset", RESERVED_WORD_ONE_RST, rsv_w);
        chk("ctrl reset", 16'h0200, {5'h00, ctrl});
        repeat (4) @(posedge clk);
        foreach (rows[i]) begin
            demux <= rows[i].dm;
            wr(ADDR_MAIN_CONFIGURATION, rows[i].d);
            chk("main word", rows[i].d, main_w);
            chk("controls", {5'h00, rows[i].ex}, {5'h00, ctrl});
            rd(ADDR_MAIN_CONFIGURATION, rows[i].d);
        end
        chk("oe idle", 16'h0000, {15'h0000, sdo_oe});
        chk("ecm", 16'h0001, {15'h0000, extended_serial_control_mode});
        base = cal_cnt;
        wr(ADDR_MAIN_CONFIGURATION, 16'h8000);
        wr(ADDR_MAIN_CONFIGURATION, 16'h8000);
        chk("cal once", 16'(base + 1), 16'(cal_cnt));
        rd(ADDR_MAIN_CONFIGURATION, 16'h8000);
        wr(ADDR_MAIN_CONFIGURATION, 16'h0000);
        wr(ADDR_MAIN_CONFIGURATION, 16'h8000);
        chk("cal again", 16'(base + 2), 16'(cal_cnt));
        wr(ADDR_MAIN_CONFIGURATION, 16'h0000);
        cal_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("cal pin", 16'(base + 3), 16'(cal_cnt));
        wr(ADDR_MAIN_CONFIGURATION, 16'h8000);
        chk("cal or", 16'(base + 3), 16'(cal_cnt));
        cal_pin <= 1'b0;
        wr(ADDR_MAIN_CONFIGURATION, 16'h0000);
        slp1_pin <= 1'b1;
        slp2_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("sleep pins", 16'h00c0, {5'h00, ctrl});
        slp1_pin <= 1'b0;
        slp2_pin <= 1'b0;
        wr(ADDR_MAIN_CONFIGURATION, 16'h1018, 20);
        chk("aborted write", 16'h0000, main_w);
        rd(4'h2, 16'h0000);
        // reserved word only ever gets its default
        wr(ADDR_RESERVED_WORD_ONE, RESERVED_WORD_ONE_RST);
        rd(ADDR_RESERVED_WORD_ONE, RESERVED_WORD_ONE_RST);
        wr(ADDR_MAIN_CONFIGURATION, 16'h1018);
        sel_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("mode exit", MAIN_CONFIGURATION_RST, main_w);
        chk("ctrl outside", 16'h0200, {5'h00, ctrl});
        wr(ADDR_MAIN_CONFIGURATION, 16'h0010);
        chk("write outside", MAIN_CONFIGURATION_RST, main_w);
        sel_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk("mode back", MAIN_CONFIGURATION_RST, main_w);
        // a frozen block must not take a whole access cycle
        ce <= 1'b0;
        wr(ADDR_MAIN_CONFIGURATION, 16'h0018);
        chk("frozen", MAIN_CONFIGURATION_RST, main_w);
        ce <= 1'b1;
        repeat (4) @(posedge clk);
        wr(ADDR_MAIN_CONFIGURATION, 16'h0018);
        chk("main before reset", 16'h0018, main_w);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("main in reset", MAIN_CONFIGURATION_RST, main_w);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk("main after reset", MAIN_CONFIGURATION_RST, main_w);
        chk("ctrl after reset", 16'h0200, {5'h00, ctrl});
        rd(ADDR_MAIN_CONFIGURATION, MAIN_CONFIGURATION_RST);
        end_of_test();
    end

    // run needs about 11500 cycles; some five times that means a hang
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
endmodule
